//--- dv/psrs_host_model.sv
// Host model driving the enable pin and the pulse wire
`timescale 1ns/1ps
module psrs_host_model (
    input wire logic clock,
    output logic enable_pin,
    output logic control_wire
);
    // Wire idles at its pulled-up level, device programmable
    initial begin
        enable_pin = 1'b0;
        control_wire = 1'b1;
    end
    // Pins move just after a rising edge only
    task automatic set_pins(input logic en, input logic wr);
        @(posedge clock);
        enable_pin <= en;
        control_wire <= wr;
    endtask
    // Only the host drives the wire; enable stays low meanwhile
    task automatic pulses(input int n, input int low_cyc);
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            control_wire <= 1'b0;
            repeat (low_cyc) @(posedge clock);
            control_wire <= 1'b1;
            repeat (9) @(posedge clock);
        end
    endtask
endmodule // psrs_host_model

//--- dv/psrs_sequencer_assertions.sv
// Port checker for the rail sequencer
`timescale 1ns/1ps
module psrs_sequencer_assertions
    import psrs_pkg::*;
#(
    parameter int unsigned SC_CYC = 20,
    parameter int unsigned INV_CYC = 50,
    parameter int unsigned REG_CYC = 200,
    parameter int unsigned FILTER_CYC = 4,
    parameter int unsigned IDLE_CYC = 30
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic enable_pin,
    input wire logic control_wire,
    input wire logic rail_at_input,
    input wire logic boost_cmd_detect,
    input wire logic inv_cmd_detect,
    input wire logic device_off,
    input wire logic [4:0] target_code,
    input wire logic [12:0] target_mv,
    input wire logic pass_switch_on,
    input wire logic pass_current_limit,
    input wire logic boost_run,
    input wire logic boost_softstart,
    input wire logic inv_run,
    input wire logic inv_softstart,
    input wire logic boost_rect_en,
    input wire logic inv_rect_en,
    input wire logic rails_good,
    input wire logic short_latched
);
    logic [15:0] ss_q, ss_d, en_q, en_d;
    // Ages of step-up soft-start and of enable high; 16 bits outlast any run
    always_comb begin
        ss_d = boost_softstart ? ss_q + 16'h0001 : 16'h0000;
        en_d = enable_pin ? en_q + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ss_q <= 16'h0000;
            en_q <= 16'h0000;
        end else begin
            ss_q <= ss_d;
            en_q <= en_d;
        end
    end
    // ****
    // Checks; pins pass a 2-FF synchroniser, so pin levels are held 4 cycles
    // ****
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_en_low; !enable_pin [*4]; endsequence
    sequence s_both_low; (!enable_pin && !control_wire) [*4]; endsequence
    sequence s_en_rise; !enable_pin ##1 enable_pin [*4]; endsequence
    a_off_all_open: assert property (s_en_low |-> !pass_switch_on && !boost_run && !inv_run
        && !boost_rect_en && !inv_rect_en) else $error("switching while enable low");
    a_both_low_idle: assert property (s_both_low |-> device_off && !short_latched
        && target_code == COUNT_DEFAULT) else $error("not idle with both pins low");
    a_enable_default: assert property (enable_pin [*4] |-> target_code == COUNT_DEFAULT)
        else $error("target not default while enabled");
    a_code_to_mv: assert property ($stable(target_code) |->
        target_mv == 13'(TARGET_TOP_MV - (int'(target_code) - 1) * TARGET_STEP_MV)) else $error("target mv wrong");
    a_code_nonzero: assert property (target_code != 5'h00) else $error("zero count applied");
    a_rise_pass_on: assert property (s_en_rise |-> pass_switch_on)
        else $error("pass switch not closed");
    a_precharge_limit: assert property (pass_current_limit |-> pass_switch_on && !boost_run)
        else $error("current limit outside precharge");
    a_latch_cause: assert property ($rose(short_latched) |-> $past(pass_switch_on) && !$past(rail_at_input))
        else $error("latch without low rail");
    a_latch_open: assert property (short_latched |-> !pass_switch_on && !boost_run && !inv_run)
        else $error("switching while latched");
    a_inv_delay: assert property ($rose(inv_softstart) |-> ss_q >= INV_CYC - 2 && ss_q <= INV_CYC + 2)
        else $error("inverting start delay wrong");
    a_reg_time: assert property ($rose(rails_good) |-> en_q >= REG_CYC)
        else $error("rails good too early");
    a_rect_boost: assert property (boost_cmd_detect [*4] |-> !boost_rect_en)
        else $error("boost rectifier on");
    a_rect_inv: assert property (inv_cmd_detect [*4] |-> !inv_rect_en) else $error("inv rectifier on");
endmodule // psrs_sequencer_assertions

//--- dv/testbench.sv
// Self-checking bench for the rail sequencer
`timescale 1ns/1ps
module testbench
    import psrs_pkg::*;
;
    localparam int unsigned SC = 20;
    localparam int unsigned INV = 50;
    localparam int unsigned REG = 200;
    typedef struct {int n; logic [4:0] code; logic [12:0] mv;} psrs_row_s;
    psrs_row_s rows [4] = '{'{1, 5'h01, 13'h1518}, '{3, 5'h03, 13'h1450},
        '{15, 5'h0F, 13'h0FA0}, '{31, 5'h1F, 13'h0960}};
    logic clock, rst_n, enable_pin, control_wire, rail_at_input, boost_cmd_detect, inv_cmd_detect;
    logic device_off, pass_switch_on, pass_current_limit, boost_run, boost_softstart, inv_run, inv_softstart;
    logic boost_rect_en, inv_rect_en, rails_good, short_latched;
    logic [4:0] target_code;
    logic [12:0] target_mv;
    int n_mismatch = 0, checks_done = 0, cyc = 0, t0;
    psrs_sequencer #(.SC_CYC(SC), .INV_CYC(INV), .REG_CYC(REG), .FILTER_CYC(4), .IDLE_CYC(30)) uut (
        .clock(clock), .rst_n(rst_n), .enable_pin(enable_pin), .control_wire(control_wire),
        .rail_at_input(rail_at_input), .boost_cmd_detect(boost_cmd_detect), .inv_cmd_detect(inv_cmd_detect),
        .device_off(device_off), .target_code(target_code), .target_mv(target_mv), .pass_switch_on(pass_switch_on),
        .pass_current_limit(pass_current_limit), .boost_run(boost_run), .boost_softstart(boost_softstart),
        .inv_run(inv_run), .inv_softstart(inv_softstart), .boost_rect_en(boost_rect_en), .inv_rect_en(inv_rect_en),
        .rails_good(rails_good), .short_latched(short_latched));
    psrs_host_model u_host (.clock(clock), .enable_pin(enable_pin), .control_wire(control_wire));
    // 25 ns clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // Bounded wait so a stuck sequencer cannot hang the run
    task automatic wait_high(ref logic sig, input int lim);
        for (int k = 0; k < lim && sig !== 1'b1; k++) @(posedge clock);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Hang guard, well above the expected few thousand cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    initial begin
        rst_n = 1'b0;
        rail_at_input = 1'b1;
        boost_cmd_detect = 1'b0;
        inv_cmd_detect = 1'b0;
        repeat (16) @(posedge clock);
        check("target_code", 16'(target_code), 16'(COUNT_DEFAULT));
        check("target_mv", 16'(target_mv), 16'h1324);
        rst_n <= 1'b1;
        // Pulse counts from the table, enable low and wire high between bursts
        foreach (rows[i]) begin
            u_host.pulses(rows[i].n, 8);
            repeat (50) @(posedge clock);
            check("target_code", 16'(target_code), 16'(rows[i].code));
            check("target_mv", 16'(target_mv), 16'(rows[i].mv));
        end
        // Two good pulses and a short glitch: the glitch is filtered
        u_host.pulses(2, 8);
        u_host.pulses(1, 2);
        repeat (50) @(posedge clock);
        check("target_code", 16'(target_code), 16'h0002);
        // A count above 31 is discarded
        u_host.pulses(32, 8);
        repeat (50) @(posedge clock);
        check("target_code", 16'(target_code), 16'h0002);
        // Start-up with a healthy rail
        u_host.set_pins(1'b1, 1'b1);
        t0 = cyc;
        repeat (6) @(posedge clock);
        check("pass_switch_on", 16'(pass_switch_on), 16'h0001);
        check("target_code", 16'(target_code), 16'(COUNT_DEFAULT));
        wait_high(boost_softstart, SC + 20);
        check("boost_softstart", 16'(boost_softstart), 16'h0001);
        check("inv_softstart", 16'(inv_softstart), 16'h0000);
        wait_high(inv_softstart, INV + 10);
        check("inv_softstart", 16'(inv_softstart), 16'h0001);
        wait_high(rails_good, REG + 20);
        check("rails_good", 16'(rails_good), 16'h0001);
        check("rails_good_age", 16'(cyc - t0 >= REG), 16'h0001);
        // Mode detector trips gate each rectifier separately
        @(posedge clock) boost_cmd_detect <= 1'b1;
        repeat (5) @(posedge clock);
        check("boost_rect_en", 16'(boost_rect_en), 16'h0000);
        check("inv_rect_en", 16'(inv_rect_en), 16'h0001);
        boost_cmd_detect <= 1'b0;
        inv_cmd_detect <= 1'b1;
        repeat (5) @(posedge clock);
        check("inv_rect_en", 16'(inv_rect_en), 16'h0000);
        check("boost_rect_en", 16'(boost_rect_en), 16'h0001);
        inv_cmd_detect <= 1'b0;
        // Enable low stops the step-up stage and opens the pass switch
        u_host.set_pins(1'b0, 1'b1);
        repeat (5) @(posedge clock);
        check("boost_run", 16'(boost_run), 16'h0000);
        check("pass_switch_on", 16'(pass_switch_on), 16'h0000);
        // Shorted rail: latch-off survives enable low, cleared by both low
        rail_at_input <= 1'b0;
        u_host.set_pins(1'b1, 1'b1);
        repeat (SC + 10) @(posedge clock);
        check("short_latched", 16'(short_latched), 16'h0001);
        check("pass_switch_on", 16'(pass_switch_on), 16'h0000);
        u_host.set_pins(1'b0, 1'b1);
        repeat (6) @(posedge clock);
        check("short_latched", 16'(short_latched), 16'h0001);
        u_host.set_pins(1'b0, 1'b0);
        repeat (6) @(posedge clock);
        check("short_latched", 16'(short_latched), 16'h0000);
        check("device_off", 16'(device_off), 16'h0001);
        // Power-up with enable already high acts as a rise
        rail_at_input <= 1'b1;
        u_host.set_pins(1'b1, 1'b1);
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        repeat (6) @(posedge clock);
        check("pass_switch_on", 16'(pass_switch_on), 16'h0001);
        print_verdict();
    end
endmodule // testbench
bind psrs_sequencer psrs_sequencer_assertions #(.SC_CYC(SC_CYC), .INV_CYC(INV_CYC), .REG_CYC(REG_CYC),
    .FILTER_CYC(FILTER_CYC), .IDLE_CYC(IDLE_CYC)) u_chk (
    .clock(clock), .rst_n(rst_n), .enable_pin(enable_pin), .control_wire(control_wire),
    .rail_at_input(rail_at_input), .boost_cmd_detect(boost_cmd_detect), .inv_cmd_detect(inv_cmd_detect),
    .device_off(device_off), .target_code(target_code), .target_mv(target_mv), .pass_switch_on(pass_switch_on),
    .pass_current_limit(pass_current_limit), .boost_run(boost_run), .boost_softstart(boost_softstart),
    .inv_run(inv_run), .inv_softstart(inv_softstart), .boost_rect_en(boost_rect_en), .inv_rect_en(inv_rect_en),
    .rails_good(rails_good), .short_latched(short_latched));

//--- logic/psrs_pkg.sv
// Constants and types shared by the pulse-set rail sequencer
package psrs_pkg;
    localparam int unsigned CLK_HZ = 40000000;
    // Short-circuit check window on the positive rail, microseconds
    localparam int unsigned SC_WINDOW_US = 100;
    localparam int unsigned SC_WINDOW_CYC = (SC_WINDOW_US * (CLK_HZ / 1000000));
    // Delay from step-up soft-start to inverting soft-start, milliseconds
    localparam int unsigned INV_DELAY_MS = 2;
    localparam int unsigned INV_DELAY_CYC = INV_DELAY_MS * (CLK_HZ / 1000);
    // Time from enable high to both rails in regulation, milliseconds
    localparam int unsigned REG_TIME_MS = 6;
    localparam int unsigned REG_TIME_CYC = REG_TIME_MS * (CLK_HZ / 1000);
    // Fastest legal pulse rate on the control wire, kHz
    localparam int unsigned WIRE_MAX_KHZ = 250;
    localparam int unsigned WIRE_MIN_PERIOD_CYC = (CLK_HZ / 1000) / WIRE_MAX_KHZ;
    // Low-level filter: a low must last a quarter of the shortest period
    localparam int unsigned FALL_FILTER_CYC = WIRE_MIN_PERIOD_CYC / 4;
    // Wire high this long ends a burst: four shortest periods
    localparam int unsigned BURST_IDLE_CYC = WIRE_MIN_PERIOD_CYC * 4;
    // Pulse count codes and target encoding
    localparam int unsigned COUNT_W = 5;
    localparam logic [COUNT_W-1:0] COUNT_MIN = 5'h01;
    localparam logic [COUNT_W-1:0] COUNT_MAX = 5'h1F;
    localparam logic [COUNT_W-1:0] COUNT_DEFAULT = 5'h06;
    // Target in millivolts magnitude: 5400 - (count-1)*100
    localparam int unsigned TARGET_TOP_MV = 5400;
    localparam int unsigned TARGET_STEP_MV = 100;
    localparam int unsigned TIMER_W = 18;

    typedef enum logic [2:0] {
        PSRS_OFF,
        PSRS_SC_CHECK,
        PSRS_LATCHED,
        PSRS_PRECHARGE,
        PSRS_BOOST_SS,
        PSRS_BOTH_SS,
        PSRS_REGULATE
    } psrs_state_e;
endpackage

//--- logic/psrs_pulse_if.sv
// Carrier between wire decoder and the sequencer top
`timescale 1ns/1ps
interface psrs_pulse_if;
    logic [4:0] count;
    logic count_valid;
    modport decoder (output count, output count_valid);
    modport top (input count, input count_valid);
endinterface

//--- logic/psrs_sequencer.sv
// Top of the pulse-set rail sequencer: mode decode, start-up and rectifier gating
`timescale 1ns/1ps
// Function
// - Counts 1..31 map to -5.4 V upward in 0.1 V steps to -2.4 V.
// - Without programming, target is -4.9 V, count six.
// - Enable and wire decoded together: off, programming, or default level.
// - Converters run only while enable is high.
// - Enable low stops switching and opens every switch; powers down (device_off) only with the wire also low.
// - Enable rise closes positive pass switch for 100 us.
// - Rail still low after window: pass switch latched open until new enable pulse.
// - Start-up on enable rise or power-up with enable high.
// - First step precharges positive rail current-limited below 400 mA; pass_current_limit rises only after the 100 us window.
// - Rail at input level: pass switch fully on, step-up soft-start begins.
// - Inverting soft-start begins 2 ms after step-up soft-start.
// - Both rails in regulation about 6 ms after enable rise.
// - Rectifier of each stage opens when its mode detector trips.
module psrs_sequencer
    import psrs_pkg::*;
#(
    parameter int unsigned SC_CYC = SC_WINDOW_CYC,
    parameter int unsigned INV_CYC = INV_DELAY_CYC,
    parameter int unsigned REG_CYC = REG_TIME_CYC,
    parameter int unsigned FILTER_CYC = FALL_FILTER_CYC,
    parameter int unsigned IDLE_CYC = BURST_IDLE_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic enable_pin,
    input wire logic control_wire,
    input wire logic rail_at_input,
    input wire logic boost_cmd_detect,
    input wire logic inv_cmd_detect,
    output logic device_off,
    output logic [4:0] target_code,
    output logic [12:0] target_mv,
    output logic pass_switch_on,
    output logic pass_current_limit,
    output logic boost_run,
    output logic boost_softstart,
    output logic inv_run,
    output logic inv_softstart,
    output logic boost_rect_en,
    output logic inv_rect_en,
    output logic rails_good,
    output logic short_latched
);
    psrs_pulse_if pulse();
    logic en_m_q, en_s_q, wr_m_q, wr_s_q, en_prev_q;
    logic init_q;
    logic bdet_m_q, bdet_s_q, idet_m_q, idet_s_q;
    psrs_state_e st_q, st_d;
    logic [TIMER_W-1:0] tmr_q, tmr_d;
    logic [TIMER_W-1:0] up_q, up_d;
    logic [4:0] code_q, code_d;
    logic [12:0] mv_q, mv_d;
    logic en_rise, all_low;

    // ***************************************************
    // Pin synchronisers
    // ***************************************************
    // Second stage only is read; first stage feeds nothing else
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            en_m_q <= 1'b0;
            en_s_q <= 1'b0;
            wr_m_q <= 1'b1;
            wr_s_q <= 1'b1;
            bdet_m_q <= 1'b0;
            bdet_s_q <= 1'b0;
            idet_m_q <= 1'b0;
            idet_s_q <= 1'b0;
            en_prev_q <= 1'b0;
            init_q <= 1'b1;
        end else begin
            en_m_q <= enable_pin;
            en_s_q <= en_m_q;
            wr_m_q <= control_wire;
            wr_s_q <= wr_m_q;
            bdet_m_q <= boost_cmd_detect;
            bdet_s_q <= bdet_m_q;
            idet_m_q <= inv_cmd_detect;
            idet_s_q <= idet_m_q;
            en_prev_q <= en_s_q;
            init_q <= 1'b0;
        end
    end

    // Power-up with enable already high counts as a rise
    assign en_rise = en_s_q && (!en_prev_q || init_q);
    assign all_low = !en_s_q && !wr_s_q;

    // ***************************************************
    // Wire decoder
    // ***************************************************
    // Pulses count whenever enable is low, whether or not the device is off
    psrs_wire_decoder #(
        .FILTER_CYC(FILTER_CYC),
        .IDLE_CYC(IDLE_CYC)
    ) u_decoder (
        .clock(clock),
        .rst_n(rst_n),
        .wire_sync(wr_s_q),
        .counting_en(!en_s_q),
        .pulse(pulse.decoder)
    );

    // ***************************************************
    // Target level selection
    // ***************************************************
    // Enable high forces default; programmed code only used when enable low
    always_comb begin
        code_d = code_q;
        if (all_low) begin
            code_d = COUNT_DEFAULT;
        end else if (en_s_q || !pulse.count_valid) begin
            code_d = COUNT_DEFAULT;
        end else if (pulse.count >= COUNT_MIN) begin
            code_d = pulse.count;
        end
        mv_d = 13'(TARGET_TOP_MV - (int'(code_d) - 1) * TARGET_STEP_MV);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            code_q <= COUNT_DEFAULT;
            mv_q <= 13'(TARGET_TOP_MV - (int'(COUNT_DEFAULT) - 1) * TARGET_STEP_MV);
        end else begin
            code_q <= code_d;
            mv_q <= mv_d;
        end
    end

    // ***************************************************
    // Start-up sequencer
    // ***************************************************
    // up_q counts from the enable rise; tmr_q times the short-circuit window and the step-up soft-start
    always_comb begin
        st_d = st_q;
        tmr_d = tmr_q;
        up_d = (up_q == TIMER_W'(REG_CYC)) ? up_q : up_q + TIMER_W'(1);
        if (!en_s_q) begin
            // Latched short survives enable low until both pins drop
            st_d = (st_q == PSRS_LATCHED && !all_low) ? PSRS_LATCHED : PSRS_OFF;
            tmr_d = '0;
            up_d = '0;
        end else if (en_rise) begin
            st_d = PSRS_SC_CHECK;
            tmr_d = '0;
            up_d = '0;
        end else begin
            unique case (st_q)
                PSRS_OFF: begin
                    tmr_d = '0;
                end
                PSRS_SC_CHECK: begin
                    tmr_d = tmr_q + TIMER_W'(1);
                    if (tmr_q >= TIMER_W'(SC_CYC - 1)) begin
                        tmr_d = '0;
                        st_d = rail_at_input ? PSRS_PRECHARGE : PSRS_LATCHED;
                    end
                end
                PSRS_LATCHED: begin
                    tmr_d = '0;
                end
                PSRS_PRECHARGE: begin
                    if (rail_at_input) begin
                        st_d = PSRS_BOOST_SS;
                        tmr_d = '0;
                    end
                end
                PSRS_BOOST_SS: begin
                    tmr_d = tmr_q + TIMER_W'(1);
                    if (tmr_q >= TIMER_W'(INV_CYC - 1)) begin
                        st_d = PSRS_BOTH_SS;
                        tmr_d = '0;
                    end
                end
                PSRS_BOTH_SS: begin
                    if (up_q >= TIMER_W'(REG_CYC)) begin
                        st_d = PSRS_REGULATE;
                    end
                end
                PSRS_REGULATE: begin
                    tmr_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= PSRS_OFF;
            tmr_q <= '0;
            up_q <= '0;
        end else begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            up_q <= up_d;
        end
    end

    // ***************************************************
    // Outputs
    // ***************************************************
    // All switches open whenever enable is low
    assign device_off = all_low;
    assign target_code = code_q;
    assign target_mv = mv_q;
    assign pass_switch_on = en_s_q && (st_q == PSRS_SC_CHECK || st_q == PSRS_PRECHARGE
        || st_q == PSRS_BOOST_SS || st_q == PSRS_BOTH_SS || st_q == PSRS_REGULATE);
    assign pass_current_limit = en_s_q && st_q == PSRS_PRECHARGE;
    assign boost_run = en_s_q && (st_q == PSRS_BOOST_SS || st_q == PSRS_BOTH_SS
        || st_q == PSRS_REGULATE);
    assign boost_softstart = en_s_q && (st_q == PSRS_BOOST_SS || st_q == PSRS_BOTH_SS);
    assign inv_run = en_s_q && (st_q == PSRS_BOTH_SS || st_q == PSRS_REGULATE);
    assign inv_softstart = en_s_q && st_q == PSRS_BOTH_SS;
    // Rectifier opens on detector trip so inductor current never reverses
    assign boost_rect_en = boost_run && !bdet_s_q;
    assign inv_rect_en = inv_run && !idet_s_q;
    assign rails_good = en_s_q && st_q == PSRS_REGULATE;
    assign short_latched = st_q == PSRS_LATCHED;
endmodule // psrs_sequencer

//--- logic/psrs_wire_decoder.sv
// Glitch filter and pulse-burst counter for the control wire
`timescale 1ns/1ps
module psrs_wire_decoder
    import psrs_pkg::*;
#(
    parameter int unsigned FILTER_CYC = FALL_FILTER_CYC,
    parameter int unsigned IDLE_CYC = BURST_IDLE_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic wire_sync,
    input wire logic counting_en,
    psrs_pulse_if.decoder pulse
);
    localparam int unsigned CW = 12;
    logic filt_q, filt_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic [CW-1:0] low_q, low_d;
    logic [5:0] pulses_q, pulses_d;
    logic [4:0] count_q, count_d;
    logic valid_q, valid_d;

    // ***************************************************
    // Filter, burst count and latch
    // ***************************************************
    // A low shorter than the filter is dropped; highs are taken at once
    always_comb begin
        filt_d = filt_q;
        cnt_d = cnt_q;
        pulses_d = pulses_q;
        count_d = count_q;
        valid_d = valid_q;
        low_d = '0;
        if (!counting_en) begin
            cnt_d = '0;
            pulses_d = '0;
            filt_d = wire_sync;
        end else if (filt_q && !wire_sync) begin
            // Own low counter: a long high before a glitch must not let it through
            cnt_d = '0;
            if (low_q >= CW'(FILTER_CYC)) begin
                filt_d = 1'b0;
                pulses_d = (pulses_q == 6'h3F) ? pulses_q : pulses_q + 6'h01;
            end else begin
                low_d = low_q + CW'(1);
            end
        end else if (!filt_q && wire_sync) begin
            filt_d = 1'b1;
            cnt_d = '0;
        end else if (filt_q && pulses_q != 6'h00) begin
            // Long high ends the burst
            if (cnt_q >= CW'(IDLE_CYC)) begin
                if (pulses_q <= {1'b0, COUNT_MAX}) begin
                    count_d = pulses_q[4:0];
                    valid_d = 1'b1;
                end
                pulses_d = '0;
                cnt_d = '0;
            end else begin
                cnt_d = cnt_q + CW'(1);
            end
        end else begin
            cnt_d = '0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            filt_q <= 1'b1;
            cnt_q <= '0;
            low_q <= '0;
            pulses_q <= '0;
            count_q <= COUNT_DEFAULT;
            valid_q <= 1'b0;
        end else begin
            filt_q <= filt_d;
            cnt_q <= cnt_d;
            low_q <= low_d;
            pulses_q <= pulses_d;
            count_q <= count_d;
            valid_q <= valid_d;
        end
    end

    assign pulse.count = count_q;
    assign pulse.count_valid = valid_q;
endmodule // psrs_wire_decoder
